//--- hw/frame_pkg.sv
// Constants, carrier types and checksum step for the control frame responder
package frame_pkg;
	localparam int NUM_CONN = 5;
	localparam int CONN_W = 3;
	localparam logic [15:0] PREAMBLE = 16'ha1ec;
	localparam logic [7:0] PROTO_REV = 8'h03;
	localparam logic [7:0] CMD_READ = 8'h03;
	localparam logic [7:0] CMD_WRITE = 8'h04;
	localparam logic [7:0] CMD_RESET = 8'h05;
	localparam logic [7:0] CMD_FLASH = 8'h06;
	localparam logic [7:0] CMD_ALIVE = 8'h07;
	localparam logic [7:0] STAT_OK = 8'h00;
	localparam logic [7:0] STAT_BAD_ADDR = 8'h0f;
	localparam logic [7:0] STAT_HDR_CRC = 8'hfb;
	localparam logic [7:0] STAT_LEN_ZERO = 8'hfd;
	localparam logic [7:0] STAT_UNKNOWN = 8'hff;
	localparam logic [5:0] OFS_MARK_HI = 6'h00;
	localparam logic [5:0] OFS_MARK_LO = 6'h01;
	localparam logic [5:0] OFS_REV = 6'h02;
	localparam logic [5:0] OFS_CMD = 6'h03;
	localparam logic [5:0] OFS_SUB = 6'h04;
	localparam logic [5:0] OFS_STATUS = 6'h05;
	localparam logic [5:0] OFS_FLAGS_HI = 6'h06;
	localparam logic [5:0] OFS_FLAGS_LO = 6'h07;
	localparam logic [5:0] OFS_LEN0 = 6'h08;
	localparam logic [5:0] OFS_LEN1 = 6'h09;
	localparam logic [5:0] OFS_LEN2 = 6'h0a;
	localparam logic [5:0] OFS_LEN3 = 6'h0b;
	localparam logic [5:0] OFS_ADDR_HI = 6'h0c;
	localparam logic [5:0] OFS_ADDR_LO = 6'h0d;
	localparam logic [5:0] OFS_CRC_END = 6'h3d;
	localparam logic [5:0] OFS_HCRC_HI = 6'h3e;
	localparam logic [5:0] OFS_HCRC_LO = 6'h3f;
	localparam logic [15:0] RESP_FLAGS = 16'h0001;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'h0000;
	localparam logic [32:0] REG_COUNT = 33'h0_0001_0000;
	localparam int IDLE_TIMEOUT_S = 10;
	localparam int CLK_HZ = 100_000_000;
	localparam int IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_S * CLK_HZ;
	localparam logic [1:0] NET_SEL_IP = 2'h0;
	localparam logic [1:0] NET_SEL_MASK = 2'h1;
	localparam logic [1:0] NET_SEL_PORT = 2'h2;
	localparam logic [1:0] NET_SEL_GW = 2'h3;
	localparam logic [31:0] NET_IP_RST = 32'hc0a8_000a;
	localparam logic [31:0] NET_MASK_RST = 32'hffff_ff00;
	localparam logic [31:0] NET_GW_RST = 32'h0000_0000;
	localparam logic [15:0] NET_PORT_RST = 16'h2711;

	typedef enum {S_IDLE, S_HDR, S_FETCH, S_DATA_HI, S_DATA_LO} resp_state_t;

	typedef struct packed {
		logic [5:0] pos;
		logic [15:0] crc;
		logic [7:0] rev;
		logic [7:0] cmd;
		logic [7:0] sub;
		logic [31:0] len;
		logic [15:0] addr;
		logic [7:0] crc_hi;
	} parse_t;

	typedef struct packed {
		logic [2:0] conn;
		logic [7:0] cmd;
		logic [7:0] sub;
		logic [7:0] status;
		logic [31:0] len;
		logic [15:0] addr;
	} job_t;

	typedef struct packed {
		logic [31:0] ip;
		logic [31:0] mask;
		logic [31:0] gw;
		logic [15:0] port;
	} net_cfg_t;

	function automatic logic [15:0] crc16_step(input logic [15:0] crc_in, input logic [7:0] b);
		logic [15:0] c;
		c = crc_in;
		for (int i = 7; i >= 0; i--) begin
			c = c[15] ^ b[i] ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
		end
		return c;
	endfunction
endpackage

//--- hw/control_frame_register_read.sv
// Control frame parser and responder with connection timeouts and network settings
module control_frame_register_read #(
	parameter int unsigned IDLE_TIMEOUT_CYCLES = frame_pkg::IDLE_TIMEOUT_CYC
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [frame_pkg::NUM_CONN-1:0] conn_open,
	output logic [frame_pkg::NUM_CONN-1:0] conn_active,
	output logic [frame_pkg::NUM_CONN-1:0] conn_close,
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic [7:0] rx_byte,
	input wire logic [frame_pkg::CONN_W-1:0] rx_conn,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [7:0] tx_byte,
	output logic [frame_pkg::CONN_W-1:0] tx_conn,
	output logic reg_rd_req,
	output logic [15:0] reg_rd_addr,
	input wire logic reg_rd_ack,
	input wire logic [15:0] reg_rd_data,
	output logic cmd_event,
	output logic [7:0] cmd_code,
	output logic [frame_pkg::CONN_W-1:0] cmd_conn,
	input wire logic net_cfg_wr,
	input wire logic [1:0] net_cfg_sel,
	input wire logic [31:0] net_cfg_data,
	output frame_pkg::net_cfg_t net_active
);
	frame_pkg::parse_t parse_reg [frame_pkg::NUM_CONN];
	frame_pkg::parse_t cur;
	frame_pkg::parse_t parse_next;
	frame_pkg::job_t job_reg;
	frame_pkg::resp_state_t state_reg;
	frame_pkg::net_cfg_t net_staged_reg;
	logic job_valid_reg;
	logic conn_ok;
	logic rx_take;
	logic hdr_done;
	logic [7:0] status_next;
	logic [15:0] rx_crc;
	logic [32:0] end_index;
	logic known_cmd;
	logic [5:0] hdr_idx_reg;
	logic [15:0] resp_crc_reg;
	logic [30:0] words_reg;
	logic [15:0] rd_addr_reg;
	logic [15:0] data_reg;
	logic [7:0] hdr_byte;
	logic [7:0] out_byte;
	logic tx_ld;
	logic emit;
	logic finish;
	logic tx_valid_reg;
	logic [7:0] tx_byte_reg;
	logic [frame_pkg::CONN_W-1:0] tx_conn_reg;
	logic cmd_event_reg;
	logic [7:0] cmd_code_reg;
	logic [frame_pkg::CONN_W-1:0] cmd_conn_reg;
	logic [31:0] idle_cnt [frame_pkg::NUM_CONN];
	logic active_reg [frame_pkg::NUM_CONN];
	logic close_reg [frame_pkg::NUM_CONN];

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	// One shared responder: a finished header stalls all input until its answer is out
	assign conn_ok = (32'(rx_conn) < frame_pkg::NUM_CONN) && conn_active[rx_conn];
	assign rx_ready = !job_valid_reg;
	assign rx_take = rx_valid && rx_ready && conn_ok;
	assign cur = conn_ok ? parse_reg[rx_conn] : '0;
	assign hdr_done = rx_take && (cur.pos == frame_pkg::OFS_HCRC_LO);

	always_comb begin
		parse_next = cur;
		if (cur.pos == frame_pkg::OFS_MARK_HI) begin
			parse_next.pos = (rx_byte == frame_pkg::PREAMBLE[15:8]) ? 6'h01 : 6'h00;
		end else if (cur.pos == frame_pkg::OFS_MARK_LO) begin
			parse_next.crc = frame_pkg::CRC_INIT;
			if (rx_byte == frame_pkg::PREAMBLE[7:0]) begin
				parse_next.pos = frame_pkg::OFS_REV;
			end else begin
				parse_next.pos = (rx_byte == frame_pkg::PREAMBLE[15:8]) ? 6'h01 : 6'h00;
			end
		end else begin
			parse_next.pos = (cur.pos == frame_pkg::OFS_HCRC_LO) ? 6'h00 : cur.pos + 6'h01;
			if (cur.pos <= frame_pkg::OFS_CRC_END) begin
				parse_next.crc = frame_pkg::crc16_step(cur.crc, rx_byte);
			end
			if (cur.pos == frame_pkg::OFS_REV) begin
				parse_next.rev = rx_byte;
			end else if (cur.pos == frame_pkg::OFS_CMD) begin
				parse_next.cmd = rx_byte;
			end else if (cur.pos == frame_pkg::OFS_SUB) begin
				parse_next.sub = rx_byte;
			end else if (cur.pos >= frame_pkg::OFS_LEN0 && cur.pos <= frame_pkg::OFS_LEN3) begin
				parse_next.len = {cur.len[23:0], rx_byte};
			end else if (cur.pos == frame_pkg::OFS_ADDR_HI || cur.pos == frame_pkg::OFS_ADDR_LO) begin
				parse_next.addr = {cur.addr[7:0], rx_byte};
			end else if (cur.pos == frame_pkg::OFS_HCRC_HI) begin
				parse_next.crc_hi = rx_byte;
			end
		end
	end

	// Per-connection parse state; open and close restart the hunt for a marker
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			for (int i = 0; i < frame_pkg::NUM_CONN; i++) begin
				parse_reg[i] <= '0;
			end
		end else begin
			if (rx_take) begin
				parse_reg[rx_conn] <= parse_next;
			end
			for (int i = 0; i < frame_pkg::NUM_CONN; i++) begin
				if (conn_open[i] || close_reg[i]) begin
					parse_reg[i] <= '0;
				end
			end
		end
	end

	// Payload checksum is not checked, so a stray read payload is just dropped
	assign rx_crc = {cur.crc_hi, rx_byte};
	assign end_index = {17'h0_0000, cur.addr} + {2'b00, cur.len[31:1]};
	assign known_cmd = (cur.cmd == frame_pkg::CMD_READ) || (cur.cmd == frame_pkg::CMD_WRITE) ||
		(cur.cmd == frame_pkg::CMD_RESET) || (cur.cmd == frame_pkg::CMD_FLASH) ||
		(cur.cmd == frame_pkg::CMD_ALIVE);

	always_comb begin
		if (rx_crc != cur.crc) begin
			status_next = frame_pkg::STAT_HDR_CRC;
		end else if (cur.rev != frame_pkg::PROTO_REV || !known_cmd) begin
			status_next = frame_pkg::STAT_UNKNOWN;
		end else if (cur.cmd != frame_pkg::CMD_READ) begin
			status_next = frame_pkg::STAT_OK;
		end else if (cur.len == 32'h0000_0000) begin
			status_next = frame_pkg::STAT_LEN_ZERO;
		end else if (cur.len[0] || end_index > frame_pkg::REG_COUNT) begin
			status_next = frame_pkg::STAT_BAD_ADDR;
		end else begin
			status_next = frame_pkg::STAT_OK;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			job_reg <= '0;
			job_valid_reg <= 1'b0;
		end else if (hdr_done) begin
			job_reg.conn <= rx_conn;
			job_reg.cmd <= cur.cmd;
			job_reg.sub <= cur.sub;
			job_reg.status <= status_next;
			job_reg.addr <= cur.addr;
			job_reg.len <= (status_next == frame_pkg::STAT_OK && cur.cmd == frame_pkg::CMD_READ) ?
				cur.len : 32'h0000_0000;
			job_valid_reg <= 1'b1;
		end else if (finish) begin
			job_valid_reg <= 1'b0;
		end
	end

	// Non-read commands are executed outside; this only announces them
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cmd_event_reg <= 1'b0;
			cmd_code_reg <= 8'h00;
			cmd_conn_reg <= '0;
		end else begin
			cmd_event_reg <= hdr_done && status_next == frame_pkg::STAT_OK &&
				cur.cmd != frame_pkg::CMD_READ;
			if (hdr_done) begin
				cmd_code_reg <= cur.cmd;
				cmd_conn_reg <= rx_conn;
			end
		end
	end

	always_comb begin
		if (hdr_idx_reg == frame_pkg::OFS_MARK_HI) begin
			hdr_byte = frame_pkg::PREAMBLE[15:8];
		end else if (hdr_idx_reg == frame_pkg::OFS_MARK_LO) begin
			hdr_byte = frame_pkg::PREAMBLE[7:0];
		end else if (hdr_idx_reg == frame_pkg::OFS_REV) begin
			hdr_byte = frame_pkg::PROTO_REV;
		end else if (hdr_idx_reg == frame_pkg::OFS_CMD) begin
			hdr_byte = job_reg.cmd;
		end else if (hdr_idx_reg == frame_pkg::OFS_SUB) begin
			hdr_byte = job_reg.sub;
		end else if (hdr_idx_reg == frame_pkg::OFS_STATUS) begin
			hdr_byte = job_reg.status;
		end else if (hdr_idx_reg == frame_pkg::OFS_FLAGS_HI) begin
			hdr_byte = frame_pkg::RESP_FLAGS[15:8];
		end else if (hdr_idx_reg == frame_pkg::OFS_FLAGS_LO) begin
			hdr_byte = frame_pkg::RESP_FLAGS[7:0];
		end else if (hdr_idx_reg == frame_pkg::OFS_LEN0) begin
			hdr_byte = job_reg.len[31:24];
		end else if (hdr_idx_reg == frame_pkg::OFS_LEN1) begin
			hdr_byte = job_reg.len[23:16];
		end else if (hdr_idx_reg == frame_pkg::OFS_LEN2) begin
			hdr_byte = job_reg.len[15:8];
		end else if (hdr_idx_reg == frame_pkg::OFS_LEN3) begin
			hdr_byte = job_reg.len[7:0];
		end else if (hdr_idx_reg == frame_pkg::OFS_ADDR_HI) begin
			hdr_byte = job_reg.addr[15:8];
		end else if (hdr_idx_reg == frame_pkg::OFS_ADDR_LO) begin
			hdr_byte = job_reg.addr[7:0];
		end else if (hdr_idx_reg == frame_pkg::OFS_HCRC_HI) begin
			hdr_byte = resp_crc_reg[15:8];
		end else if (hdr_idx_reg == frame_pkg::OFS_HCRC_LO) begin
			hdr_byte = resp_crc_reg[7:0];
		end else begin
			hdr_byte = 8'h00;
		end
	end

	assign tx_ld = !tx_valid_reg || tx_ready;
	assign emit = state_reg == frame_pkg::S_HDR || state_reg == frame_pkg::S_DATA_HI ||
		state_reg == frame_pkg::S_DATA_LO;
	assign out_byte = state_reg == frame_pkg::S_HDR ? hdr_byte :
		(state_reg == frame_pkg::S_DATA_HI ? data_reg[15:8] : data_reg[7:0]);
	assign finish = tx_ld && ((state_reg == frame_pkg::S_HDR && hdr_idx_reg == frame_pkg::OFS_HCRC_LO &&
		words_reg == 31'h0000_0000) || (state_reg == frame_pkg::S_DATA_LO && words_reg == 31'h0000_0001));
	assign reg_rd_req = state_reg == frame_pkg::S_FETCH;
	assign reg_rd_addr = rd_addr_reg;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_reg <= frame_pkg::S_IDLE;
			hdr_idx_reg <= 6'h00;
			resp_crc_reg <= frame_pkg::CRC_INIT;
			words_reg <= 31'h0000_0000;
			rd_addr_reg <= 16'h0000;
			data_reg <= 16'h0000;
		end else begin
			case (state_reg)
				frame_pkg::S_IDLE: begin
					if (job_valid_reg) begin
						state_reg <= frame_pkg::S_HDR;
						hdr_idx_reg <= 6'h00;
						resp_crc_reg <= frame_pkg::CRC_INIT;
						words_reg <= job_reg.len[31:1];
						rd_addr_reg <= job_reg.addr;
					end
				end
				frame_pkg::S_HDR: begin
					if (tx_ld) begin
						hdr_idx_reg <= hdr_idx_reg + 6'h01;
						if (hdr_idx_reg >= frame_pkg::OFS_REV && hdr_idx_reg <= frame_pkg::OFS_CRC_END) begin
							resp_crc_reg <= frame_pkg::crc16_step(resp_crc_reg, hdr_byte);
						end
						if (hdr_idx_reg == frame_pkg::OFS_HCRC_LO) begin
							state_reg <= finish ? frame_pkg::S_IDLE : frame_pkg::S_FETCH;
						end
					end
				end
				frame_pkg::S_FETCH: begin
					if (reg_rd_ack) begin
						data_reg <= reg_rd_data;
						state_reg <= frame_pkg::S_DATA_HI;
					end
				end
				frame_pkg::S_DATA_HI: begin
					if (tx_ld) begin
						state_reg <= frame_pkg::S_DATA_LO;
					end
				end
				frame_pkg::S_DATA_LO: begin
					if (tx_ld) begin
						words_reg <= words_reg - 31'h0000_0001;
						rd_addr_reg <= rd_addr_reg + 16'h0001;
						state_reg <= finish ? frame_pkg::S_IDLE : frame_pkg::S_FETCH;
					end
				end
				default: state_reg <= frame_pkg::S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tx_valid_reg <= 1'b0;
			tx_byte_reg <= 8'h00;
			tx_conn_reg <= '0;
		end else if (tx_ld) begin
			tx_valid_reg <= emit;
			if (emit) begin
				tx_byte_reg <= out_byte;
				tx_conn_reg <= job_reg.conn;
			end
		end
	end

	assign tx_valid = tx_valid_reg;
	assign tx_byte = tx_byte_reg;
	assign tx_conn = tx_conn_reg;
	assign cmd_event = cmd_event_reg;
	assign cmd_code = cmd_code_reg;
	assign cmd_conn = cmd_conn_reg;

	// Only a complete valid-marker header or a conn_open pulse restarts the idle count, not stray bytes
	for (genvar i = 0; i < frame_pkg::NUM_CONN; i++) begin : g_conn
		always_ff @(posedge clk_sys) begin
			if (reset) begin
				idle_cnt[i] <= 32'h0000_0000;
				active_reg[i] <= 1'b0;
				close_reg[i] <= 1'b0;
			end else begin
				close_reg[i] <= 1'b0;
				if (conn_open[i]) begin
					active_reg[i] <= 1'b1;
					idle_cnt[i] <= 32'h0000_0000;
				end else if (active_reg[i]) begin
					if (hdr_done && 32'(rx_conn) == i) begin
						idle_cnt[i] <= 32'h0000_0000;
					end else if (idle_cnt[i] == 32'(IDLE_TIMEOUT_CYCLES - 1)) begin
						active_reg[i] <= 1'b0;
						close_reg[i] <= 1'b1;
						idle_cnt[i] <= 32'h0000_0000;
					end else begin
						idle_cnt[i] <= idle_cnt[i] + 32'h0000_0001;
					end
				end
			end
		end
		assign conn_active[i] = active_reg[i];
		assign conn_close[i] = close_reg[i];
		a_idle_close: assert property ((active_reg[i] && !conn_open[i] && !(hdr_done &&
			32'(rx_conn) == i) && idle_cnt[i] == 32'(IDLE_TIMEOUT_CYCLES - 1)) |=>
			(close_reg[i] && !active_reg[i])) else $error("idle connection not closed");
	end

	// Staged settings wait so a half-written address cannot cut the link
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			net_staged_reg <= {frame_pkg::NET_IP_RST, frame_pkg::NET_MASK_RST,
				frame_pkg::NET_GW_RST, frame_pkg::NET_PORT_RST};
			net_active <= {frame_pkg::NET_IP_RST, frame_pkg::NET_MASK_RST,
				frame_pkg::NET_GW_RST, frame_pkg::NET_PORT_RST};
		end else if (net_cfg_wr) begin
			if (net_cfg_sel == frame_pkg::NET_SEL_IP) begin
				net_staged_reg.ip <= net_cfg_data;
			end else if (net_cfg_sel == frame_pkg::NET_SEL_MASK) begin
				net_staged_reg.mask <= net_cfg_data;
			end else if (net_cfg_sel == frame_pkg::NET_SEL_PORT) begin
				net_staged_reg.port <= net_cfg_data[15:0];
			end else begin
				net_staged_reg.gw <= net_cfg_data;
				net_active <= {net_staged_reg.ip, net_staged_reg.mask, net_cfg_data,
					net_staged_reg.port};
			end
		end
	end

	a_resp_start: assert property ((state_reg == frame_pkg::S_IDLE && job_valid_reg) |=>
		(state_reg == frame_pkg::S_HDR && hdr_idx_reg == 6'h00)) else $error("response not started");
	a_rx_stall: assert property ((state_reg != frame_pkg::S_IDLE) |-> !rx_ready)
		else $error("input open while busy");
	a_marker_out: assert property ((state_reg == frame_pkg::S_HDR && tx_ld && hdr_idx_reg == 6'h00)
		|=> (tx_valid && tx_byte == 8'ha1)) else $error("response marker wrong");
	a_crc_status: assert property ((hdr_done && rx_crc != cur.crc) |=>
		(job_reg.status == 8'hfb)) else $error("checksum error not reported");
	a_zero_len: assert property ((hdr_done && rx_crc == cur.crc && cur.rev == 8'h03 &&
		cur.cmd == 8'h03 && cur.len == 32'h0000_0000) |=> (job_reg.status == 8'hfd))
		else $error("zero length not rejected");
	a_unknown_cmd: assert property ((hdr_done && rx_crc == cur.crc && !known_cmd) |=>
		(job_reg.status == 8'hff)) else $error("unknown command accepted");
	a_addr_step: assert property ((state_reg == frame_pkg::S_DATA_LO && tx_ld &&
		words_reg > 31'h0000_0001) |=> (rd_addr_reg == $past(rd_addr_reg) + 16'h0001))
		else $error("register address not advanced");
	a_data_order: assert property ((state_reg == frame_pkg::S_FETCH && reg_rd_ack) ##1
		(tx_ld && state_reg == frame_pkg::S_DATA_HI) |=> (tx_byte == $past(data_reg[15:8], 1)))
		else $error("data high byte not first");
	a_net_hold: assert property ((net_cfg_wr && net_cfg_sel != frame_pkg::NET_SEL_GW) |=>
		$stable(net_active)) else $error("setting applied before gateway write");

	c_read_ok: cover property (hdr_done && status_next == frame_pkg::STAT_OK &&
		cur.cmd == frame_pkg::CMD_READ);
	c_crc_bad: cover property (hdr_done && status_next == frame_pkg::STAT_HDR_CRC);
	c_timeout: cover property (conn_close != '0);
	c_stall: cover property (tx_valid && !tx_ready ##1 tx_valid);
endmodule // control_frame_register_read

//--- bench/reg_source.sv
// Register store model that answers the block's register reads
module reg_source (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic slow,
	input wire logic reg_rd_req,
	input wire logic [15:0] reg_rd_addr,
	output logic reg_rd_ack,
	output logic [15:0] reg_rd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] wait_reg;
	logic give;
	// Slow mode stalls three cycles so the read path must hold its request
	assign give = reg_rd_req && !reg_rd_ack && (!slow || wait_reg == 2'h3);
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wait_reg <= 2'h0;
			reg_rd_ack <= 1'b0;
			reg_rd_data <= 16'h0000;
		end else begin
			reg_rd_ack <= give;
			wait_reg <= (reg_rd_req && !reg_rd_ack) ? wait_reg + 2'h1 : 2'h0;
			// Outside an answer the data lines flip so stale values never pass
			reg_rd_data <= give ? (reg_rd_addr ^ 16'h3c3c) : ~reg_rd_data;
		end
	end
endmodule // reg_source

//--- bench/control_frame_register_read_tb.sv
// Self-checking bench for the control frame responder
module control_frame_register_read_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int IDLE = 300;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [4:0] conn_open = 5'h00;
	logic [4:0] conn_active, conn_close;
	logic rx_valid = 1'b0, rx_ready, tx_valid, tx_ready = 1'b1;
	logic [7:0] rx_byte = 8'h00, tx_byte, cmd_code;
	logic [2:0] rx_conn = 3'h0, tx_conn, cmd_conn;
	logic reg_rd_req, reg_rd_ack, cmd_event, slow = 1'b0, net_cfg_wr = 1'b0;
	logic [15:0] reg_rd_addr, reg_rd_data;
	logic [1:0] net_cfg_sel = 2'h0;
	logic [31:0] net_cfg_data = 32'h0000_0000;
	frame_pkg::net_cfg_t net_active;
	int miscompares = 0, n_checks = 0, n_evt = 0;
	logic lead_junk = 1'b0;
	logic [7:0] hdr [64];
	logic [7:0] e [64];
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (cmd_event === 1'b1) n_evt++;
	// Slow mode makes the sink accept only every other cycle
	always @(posedge clk_sys) tx_ready <= slow ? ~tx_ready : 1'b1;
	control_frame_register_read #(.IDLE_TIMEOUT_CYCLES(IDLE)) dut_u (.clk_sys(clk_sys),
		.reset(reset), .conn_open(conn_open), .conn_active(conn_active),
		.conn_close(conn_close), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_byte(rx_byte),
		.rx_conn(rx_conn), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte),
		.tx_conn(tx_conn), .reg_rd_req(reg_rd_req), .reg_rd_addr(reg_rd_addr),
		.reg_rd_ack(reg_rd_ack), .reg_rd_data(reg_rd_data), .cmd_event(cmd_event),
		.cmd_code(cmd_code), .cmd_conn(cmd_conn), .net_cfg_wr(net_cfg_wr),
		.net_cfg_sel(net_cfg_sel), .net_cfg_data(net_cfg_data), .net_active(net_active));
	reg_source part_u (.clk_sys(clk_sys), .reset(reset), .slow(slow),
		.reg_rd_req(reg_rd_req), .reg_rd_addr(reg_rd_addr), .reg_rd_ack(reg_rd_ack),
		.reg_rd_data(reg_rd_data));
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk_byte(string nm, logic [7:0] x, logic [7:0] g);
		n_checks++;
		if (g !== x) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, x, g);
		end
	endtask
	task automatic chk_val(string nm, logic [111:0] x, logic [111:0] g);
		n_checks++;
		if (g !== x) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, x, g);
		end
	endtask
	task automatic hang(string nm);
		miscompares++;
		$display("ERROR %s expected handshake seen none", nm);
		finish_test();
	endtask
	function automatic logic [15:0] crc(input logic [7:0] b [64]);
		logic [15:0] c;
		c = 16'h0000;
		for (int i = 2; i < 62; i++) begin
			for (int k = 7; k >= 0; k--) begin
				c = (c[15] ^ b[i][k]) ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
			end
		end
		return c;
	endfunction
	// Byte is held until rx_ready is seen high before the taking edge
	task automatic put_byte(logic [2:0] c, logic [7:0] b);
		int k;
		k = 0;
		rx_valid <= 1'b1;
		rx_conn <= c;
		rx_byte <= b;
		@(negedge clk_sys);
		while (rx_ready !== 1'b1) begin
			@(negedge clk_sys);
			k++;
			if (k > 500) hang("rx_ready");
		end
		@(posedge clk_sys);
	endtask
	task automatic take(logic [2:0] c, string nm, logic [7:0] x);
		int k;
		k = 0;
		@(negedge clk_sys);
		while (!(tx_valid === 1'b1 && tx_ready === 1'b1)) begin
			@(negedge clk_sys);
			k++;
			if (k > 500) hang(nm);
		end
		chk_byte(nm, x, tx_byte);
		chk_byte("tx_conn", {5'h00, c}, {5'h00, tx_conn});
	endtask
	task automatic frame(logic [2:0] c, logic [7:0] v, m, logic [31:0] n, logic [15:0] a,
			logic bad, logic [7:0] st);
		logic [15:0] w;
		@(posedge clk_sys);
		conn_open <= 5'h01 << c;
		@(posedge clk_sys);
		conn_open <= 5'h00;
		@(posedge clk_sys);
		// Garbage on an already open link, so the marker hunt must resync by itself
		if (lead_junk) begin
			put_byte(c, 8'h55);
			put_byte(c, 8'ha1);
			put_byte(c, 8'h00);
			put_byte(c, 8'ha1);
		end
		hdr = '{default: 8'h00};
		{hdr[0], hdr[1], hdr[2], hdr[3]} = {16'ha1ec, v, m};
		{hdr[4], hdr[5], hdr[16]} = {8'h5a, 8'h77, 8'h99};
		{hdr[8], hdr[9], hdr[10], hdr[11], hdr[12], hdr[13]} = {n, a};
		{hdr[62], hdr[63]} = crc(hdr) ^ {15'h0000, bad};
		for (int i = 0; i < 64; i++) put_byte(c, hdr[i]);
		rx_valid <= 1'b0;
		e = '{default: 8'h00};
		{e[0], e[1], e[2], e[3], e[4], e[5], e[7]} = {16'ha1ec, 8'h03, m, 8'h5a, st, 8'h01};
		if (m == 8'h03 && st == 8'h00) {e[8], e[9], e[10], e[11]} = n;
		{e[12], e[13]} = a;
		{e[62], e[63]} = crc(e);
		for (int i = 0; i < 64; i++) take(c, "resp_hdr", e[i]);
		for (int j = 0; m == 8'h03 && st == 8'h00 && j < n / 2; j++) begin
			w = (a + 16'(j)) ^ 16'h3c3c;
			take(c, "resp_hi", w[15:8]);
			take(c, "resp_lo", w[7:0]);
		end
		repeat (4) @(negedge clk_sys);
		chk_byte("extra_resp", 8'h00, {7'h00, tx_valid});
	endtask
	task automatic t_read();
		frame(3'h0, 8'h03, 8'h03, 32'h0000_0006, 16'h0100, 1'b0, 8'h00);
		@(posedge clk_sys);
		slow <= 1'b1;
		frame(3'h4, 8'h03, 8'h03, 32'h0000_0002, 16'hffff, 1'b0, 8'h00);
		@(posedge clk_sys);
		slow <= 1'b0;
		$display("read test done");
	endtask
	task automatic t_errors();
		frame(3'h0, 8'h03, 8'h03, 32'h0000_0004, 16'h0010, 1'b1, 8'hfb);
		frame(3'h0, 8'h03, 8'h03, 32'h0000_0000, 16'h0010, 1'b0, 8'hfd);
		frame(3'h0, 8'h03, 8'h03, 32'h0000_0003, 16'h0010, 1'b0, 8'h0f);
		frame(3'h0, 8'h03, 8'h03, 32'h0000_0004, 16'hffff, 1'b0, 8'h0f);
		frame(3'h0, 8'h03, 8'h09, 32'h0000_0002, 16'h0010, 1'b0, 8'hff);
		frame(3'h0, 8'h02, 8'h03, 32'h0000_0002, 16'h0010, 1'b0, 8'hff);
		$display("error test done");
	endtask
	task automatic t_codes();
		int base;
		base = n_evt;
		for (int i = 4; i < 8; i++) begin
			frame(3'h1, 8'h03, 8'(i), 32'h0000_0002, 16'h0020, 1'b0, 8'h00);
			chk_val("cmd_events", 112'(base + i - 3), 112'(n_evt));
			chk_byte("cmd_code", 8'(i), cmd_code);
			chk_byte("cmd_conn", 8'h01, {5'h00, cmd_conn});
		end
		$display("code test done");
	endtask
	// Stray marker bytes ahead of a real header must not derail the parse
	task automatic t_hunt();
		frame(3'h2, 8'h03, 8'h03, 32'h0000_0002, 16'h0040, 1'b0, 8'h00);
		lead_junk = 1'b1;
		frame(3'h2, 8'h03, 8'h03, 32'h0000_0004, 16'h0041, 1'b0, 8'h00);
		lead_junk = 1'b0;
		$display("hunt test done");
	endtask
	task automatic t_net();
		@(posedge clk_sys);
		{net_cfg_wr, net_cfg_sel, net_cfg_data} <= {1'b1, 2'h0, 32'h0a00_0005};
		@(posedge clk_sys);
		{net_cfg_sel, net_cfg_data} <= {2'h2, 32'h0000_1234};
		@(posedge clk_sys);
		net_cfg_wr <= 1'b0;
		@(negedge clk_sys);
		chk_val("net_staged", {32'hc0a8_000a, 32'hffff_ff00, 32'h0000_0000, 16'h2711},
			net_active);
		@(posedge clk_sys);
		{net_cfg_wr, net_cfg_sel, net_cfg_data} <= {1'b1, 2'h3, 32'h0a00_0001};
		@(posedge clk_sys);
		net_cfg_wr <= 1'b0;
		@(negedge clk_sys);
		chk_val("net_applied", {32'h0a00_0005, 32'hffff_ff00, 32'h0a00_0001, 16'h1234},
			net_active);
		$display("net test done");
	endtask
	task automatic t_timeout();
		int k;
		k = 0;
		@(posedge clk_sys);
		conn_open <= 5'h08;
		@(posedge clk_sys);
		conn_open <= 5'h00;
		repeat (IDLE - 10) @(posedge clk_sys);
		@(negedge clk_sys);
		chk_byte("active_held", 8'h01, {7'h00, conn_active[3]});
		while (conn_close[3] !== 1'b1) begin
			@(negedge clk_sys);
			k++;
			if (k > 20) hang("conn_close");
		end
		@(negedge clk_sys);
		chk_byte("active_drop", 8'h00, {7'h00, conn_active[3]});
		chk_byte("close_pulse", 8'h00, {7'h00, conn_close[3]});
		chk_val("idle_cycles", 112'(10), 112'(k));
		$display("timeout test done");
	endtask
	initial begin
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		@(negedge clk_sys);
		chk_val("net_reset", {32'hc0a8_000a, 32'hffff_ff00, 32'h0000_0000, 16'h2711},
			net_active);
		chk_byte("rx_ready", 8'h01, {7'h00, rx_ready});
		$display("reset test done");
		t_read();
		t_errors();
		t_codes();
		t_hunt();
		t_net();
		t_timeout();
		finish_test();
	end
endmodule // control_frame_register_read_tb
